// *** verification/bus_node_model.sv ***
// Behavioural bus engine standing at the block's far side
`timescale 1ns/1ps
`include "lin_can_consts.vh"
module bus_node_model #(
  parameter integer DONE_GAP = 3
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Transmit handshake
  input wire tx_valid,
  input wire [`ITEM_W-1:0] tx_item,
  output reg tx_ready = 1'h0,
  output reg tx_done = 1'h0,
  // Line activity and test control
  output reg bus_activity = 1'h0,
  input wire stall,
  input wire quiet
);
  reg [`ITEM_W-1:0] sent [0:15];
  integer sent_n = 0;
  integer gap = 0;
  integer tick = 0;
  always @(posedge mclk) begin
    if (rstn && tx_valid && tx_ready) begin
      sent[sent_n % 16] = tx_item;
      sent_n = sent_n + 1;
      gap = DONE_GAP;
    end
  end
  // A frame occupies the wire a few cycles, so ready stays low meanwhile
  always @(negedge mclk) begin
    tx_done <= gap == 1;
    if (gap > 0)
      gap = gap - 1;
    tx_ready <= rstn && !stall && gap == 0;
    tick = tick + 1;
    bus_activity <= rstn && !quiet && tick % 16 == 0;
  end
endmodule

// *** verification/lin_can_frame_queue_status_chk.sv ***
// Port checker for the frame queue and status block
`timescale 1ns/1ps
`include "lin_can_consts.vh"
module lin_can_frame_queue_status_chk (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Host side
  input wire comm_start,
  input wire wr_valid,
  input wire rd_req,
  input wire [`ITEM_W-1:0] rd_item,
  input wire rd_valid,
  input wire stale_data_warning,
  input wire write_overflow_error,
  // Flags
  input wire read_available_state,
  input wire multi_read_threshold_state,
  input wire write_done_state,
  // Bus side
  input wire rx_valid,
  input wire [11:0] rx_id,
  input wire [11:0] obj_id,
  input wire trig_out_en,
  input wire tx_valid,
  input wire [`ITEM_W-1:0] tx_item,
  input wire tx_ready,
  input wire trigger_line_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_ans; rd_req |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_stale; rd_req && !read_available_state |=> stale_data_warning && $stable(rd_item);
  endproperty
  a_stale: assert property (p_stale) else $error("empty read not repeated");
  property p_fresh; rd_req && read_available_state |=> !stale_data_warning; endproperty
  a_fresh: assert property (p_fresh) else $error("stale flag on fresh read");
  property p_avail; read_available_state && !rd_req && !comm_start |=> read_available_state;
  endproperty
  a_avail: assert property (p_avail) else $error("read available dropped");
  property p_mult; multi_read_threshold_state |-> read_available_state; endproperty
  a_mult: assert property (p_mult) else $error("multi read on empty queue");
  property p_wd_clr; wr_valid && !comm_start |=> !write_done_state; endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("write done kept after write");
  property p_wd_hold; write_done_state && !wr_valid && !comm_start |=> write_done_state;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("write done dropped");
  property p_wd_start; comm_start && !wr_valid |=> write_done_state; endproperty
  a_wd_start: assert property (p_wd_start) else $error("write done low at start");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_item); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit item lost");
  property p_trig;
    trigger_line_out |-> $past(rx_valid) && $past(trig_out_en) && $past(rx_id) == $past(obj_id);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse without match");
  property p_ovf; write_overflow_error |-> $past(wr_valid); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without write");
endmodule

// *** verification/lin_can_frame_queue_status_test.sv ***
// Self-checking bench for the frame queue and status block
`timescale 1ns/1ps
`include "lin_can_consts.vh"
module lin_can_frame_queue_status_test;
  localparam [`ITEM_W-1:0] ALL = 32'hffff_ffff;
  localparam [`ITEM_W-1:0] KIND = 32'hf000_0000;
  reg mclk, rstn, comm_start, log_bus_errors, trig_log_en, trig_out_en, sleep_attr, ovf;
  reg wr_valid, rd_req, rx_valid, rx_error, break_sync, trigger_line, stall, quiet, wakeup_cmd;
  reg trig_tx_en, auto_answer_en;
  reg [3:0] rd_depth_cfg, wr_depth_cfg, notify_threshold_length, rx_kind;
  reg [11:0] obj_id, rx_id;
  reg [15:0] rx_data;
  reg [`ITEM_W-1:0] wr_item;
  wire [`ITEM_W-1:0] rd_item, tx_item;
  wire write_overflow_error, rd_valid, stale_data_warning, read_overflow, read_available_state;
  wire multi_read_threshold_state, write_done_state, sleeping, tx_valid, tx_ready, tx_done;
  wire wakeup_req, trigger_line_out, bus_activity;
  integer err_count, checks, i, n;

  always #2.5 mclk = ~mclk;

  lin_can_frame_queue_status #(.INACT_CYCLES(32'h12c), .REMOTE_CYCLES(32'h14)) u_dut (
    .mclk(mclk), .rstn(rstn), .comm_start(comm_start), .rd_depth_cfg(rd_depth_cfg),
    .wr_depth_cfg(wr_depth_cfg), .notify_threshold_length(notify_threshold_length),
    .log_bus_errors(log_bus_errors), .trig_log_en(trig_log_en), .trig_out_en(trig_out_en),
    .trig_tx_en(trig_tx_en), .auto_answer_en(auto_answer_en), .remote_mode(2'h0),
    .obj_id(obj_id), .obj_data(16'h0), .sleep_attr(sleep_attr), .wakeup_cmd(wakeup_cmd),
    .wr_valid(wr_valid), .wr_item(wr_item), .write_overflow_error(write_overflow_error),
    .rd_req(rd_req), .rd_item(rd_item), .rd_valid(rd_valid),
    .stale_data_warning(stale_data_warning), .read_overflow(read_overflow),
    .read_available_state(read_available_state),
    .multi_read_threshold_state(multi_read_threshold_state),
    .write_done_state(write_done_state), .sleeping(sleeping), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_id(rx_id), .rx_data(rx_data), .rx_error(rx_error),
    .bus_activity(bus_activity), .break_sync(break_sync), .tx_valid(tx_valid),
    .tx_item(tx_item), .tx_ready(tx_ready), .tx_done(tx_done), .wakeup_req(wakeup_req),
    .trigger_line(trigger_line), .trigger_line_out(trigger_line_out));

  bus_node_model u_node (.mclk(mclk), .rstn(rstn), .tx_valid(tx_valid), .tx_item(tx_item),
    .tx_ready(tx_ready), .tx_done(tx_done), .bus_activity(bus_activity), .stall(stall),
    .quiet(quiet));

  function [`ITEM_W-1:0] full(input [11:0] id);
    full = {4'h2, id, 4'h0, id};
  endfunction

  task chk(input [`ITEM_W-1:0] g, input [`ITEM_W-1:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        err_count = err_count + 1;
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Bounded wait: 0 read available, 1 write done, 2 awake
  task wait_on(input integer w);
    begin
      n = 0;
      while ((w == 0 ? read_available_state : w == 1 ? write_done_state : !sleeping) !== 1'h1
             && n < 500) begin
        @(negedge mclk);
        n = n + 1;
      end
      if (n == 500) begin
        err_count = err_count + 1;
        report_and_stop;
      end
    end
  endtask

  task rx(input [3:0] k, input [11:0] id, input err);
    begin
      @(negedge mclk);
      {rx_valid, rx_kind, rx_id, rx_data, rx_error} = {1'h1, k, id, 4'h0, id, err};
      @(negedge mclk);
      rx_valid = 1'h0;
    end
  endtask

  task rd(input [`ITEM_W-1:0] e, input [`ITEM_W-1:0] m, input s);
    begin
      @(negedge mclk);
      rd_req = 1'h1;
      @(posedge mclk);
      #1;
      chk(rd_valid, 1'h1);
      chk(stale_data_warning, s);
      chk(rd_item & m, e);
      @(negedge mclk);
      rd_req = 1'h0;
    end
  endtask

  task wr(input [`ITEM_W-1:0] it);
    begin
      @(negedge mclk);
      wr_valid = 1'h1;
      wr_item = it;
      @(posedge mclk);
      #1;
      ovf = write_overflow_error;
      @(negedge mclk);
      wr_valid = 1'h0;
    end
  endtask

  task start(input [3:0] depth);
    begin
      @(negedge mclk);
      rd_depth_cfg = depth;
      comm_start = 1'h1;
      @(negedge mclk);
      comm_start = 1'h0;
    end
  endtask

  initial begin
    {mclk, rstn, comm_start, log_bus_errors, trig_log_en, trig_out_en, sleep_attr} = '0;
    {wr_valid, rd_req, rx_valid, rx_error, break_sync, trigger_line, stall, quiet} = '0;
    {wakeup_cmd, rx_kind, rx_id, rx_data, wr_item, ovf, trig_tx_en, auto_answer_en} = '0;
    err_count = 0;
    checks = 0;
    wr_depth_cfg = 4'h2;
    notify_threshold_length = 4'h1;
    obj_id = 12'h123;
    repeat (12) @(negedge mclk);
    rstn = 1'h1;
    start(4'h4);
    @(posedge mclk);
    #1;
    chk(write_done_state, 1'h1);
    rd(32'h0, ALL, 1'h1);
    for (i = 1; i < 4; i = i + 1)
      rx(4'h2, i, 1'h0);
    @(negedge mclk);
    chk(read_available_state, 1'h1);
    chk(multi_read_threshold_state, 1'h1);
    for (i = 1; i < 4; i = i + 1) begin
      rd(full(i), ALL, 1'h0);
      if (i == 2)
        chk(multi_read_threshold_state, 1'h0);
    end
    chk(read_available_state, 1'h0);
    rd(full(12'h3), ALL, 1'h1);
    log_bus_errors = 1'h1;
    rx(4'h2, 12'h0aa, 1'h1);
    wait_on(0);
    rd({4'h3, 28'h0}, KIND, 1'h0);
    log_bus_errors = 1'h0;
    rx(4'h2, 12'h0ab, 1'h1);
    repeat (2) @(negedge mclk);
    chk(read_available_state, 1'h0);
    rx(4'h5, 12'h03c, 1'h0);
    wait_on(0);
    rd({4'h2, 12'h03c, 16'h0}, 32'hffff_0000, 1'h0);
    trig_log_en = 1'h1;
    trigger_line = 1'h1;
    wait_on(0);
    rd({4'h6, 28'h0}, KIND, 1'h0);
    trigger_line = 1'h0;
    trig_out_en = 1'h1;
    rx(4'h2, 12'h123, 1'h0);
    chk(trigger_line_out, 1'h1);
    rx(4'h2, 12'h124, 1'h0);
    chk(trigger_line_out, 1'h0);
    rd(full(12'h123), ALL, 1'h0);
    rd(full(12'h124), ALL, 1'h0);
    // Stalled far side: queue fills behind one buffered item until a write is refused
    stall = 1'h1;
    n = 0;
    for (i = 0; i < 8; i = i + 1) begin
      wr({4'h1, i[11:0], 16'h0});
      if (!ovf)
        n = n + 1;
    end
    chk(ovf, 1'h1);
    i = n;
    stall = 1'h0;
    wait_on(1);
    chk(u_node.sent_n, i);
    for (n = 0; n < i; n = n + 1)
      chk(u_node.sent[n], {4'h1, n[11:0], 16'h0});
    trig_log_en = 1'h0;
    trig_tx_en = 1'h1;
    trigger_line = 1'h1;
    repeat (8) @(negedge mclk);
    chk(u_node.sent[3], 32'h7123_0000);
    trig_tx_en = 1'h0;
    trigger_line = 1'h0;
    auto_answer_en = 1'h1;
    rx(4'h8, 12'h123, 1'h0);
    repeat (8) @(negedge mclk);
    chk(u_node.sent_n, 5);
    chk(u_node.sent[4], 32'h7123_0000);
    rd(32'h8123_0123, ALL, 1'h0);
    auto_answer_en = 1'h0;
    quiet = 1'h1;
    sleep_attr = 1'h1;
    repeat (2) @(negedge mclk);
    chk(sleeping, 1'h1);
    rx(4'h2, 12'h055, 1'h0);
    repeat (2) @(negedge mclk);
    chk(read_available_state, 1'h0);
    sleep_attr = 1'h0;
    wakeup_cmd = 1'h1;
    @(negedge mclk);
    wakeup_cmd = 1'h0;
    chk(wakeup_req, 1'h1);
    wait_on(2);
    wait_on(0);
    rd({4'h4, 28'h0}, KIND, 1'h0);
    rx(4'h2, 12'h066, 1'h0);
    repeat (2) @(negedge mclk);
    chk(read_available_state, 1'h0);
    break_sync = 1'h1;
    quiet = 1'h0;
    @(negedge mclk);
    break_sync = 1'h0;
    rx(4'h2, 12'h067, 1'h0);
    wait_on(0);
    rd(full(12'h067), ALL, 1'h0);
    start(4'h0);
    rx(4'h2, 12'h071, 1'h0);
    rx(4'h2, 12'h072, 1'h0);
    @(posedge mclk);
    #1;
    chk(read_overflow, 1'h0);
    rd(full(12'h072), ALL, 1'h0);
    chk(read_available_state, 1'h0);
    report_and_stop;
  end
endmodule

bind lin_can_frame_queue_status lin_can_frame_queue_status_chk u_chk (.mclk(mclk), .rstn(rstn),
  .comm_start(comm_start), .wr_valid(wr_valid), .rd_req(rd_req), .rd_item(rd_item),
  .rd_valid(rd_valid), .stale_data_warning(stale_data_warning),
  .write_overflow_error(write_overflow_error), .read_available_state(read_available_state),
  .multi_read_threshold_state(multi_read_threshold_state), .write_done_state(write_done_state),
  .rx_valid(rx_valid), .rx_id(rx_id), .obj_id(obj_id), .trig_out_en(trig_out_en),
  .tx_valid(tx_valid), .tx_item(tx_item), .tx_ready(tx_ready),
  .trigger_line_out(trigger_line_out));

// *** verilog/lin_can_consts.vh ***
// Constants for the frame queue and status block
`ifndef LIN_CAN_CONSTS_VH
`define LIN_CAN_CONSTS_VH

// Queue item layout: kind, identifier, payload
`define ITEM_W 32
`define KIND_HI 31
`define KIND_LO 28
`define ID_HI 27
`define ID_LO 16
`define PAY_HI 15
`define PAY_LO 0

// Item kinds
`define KIND_NONE 4'h0
`define KIND_HEADER 4'h1
`define KIND_FULL 4'h2
`define KIND_BUS_ERR 4'h3
`define KIND_INACTIVE 4'h4
`define KIND_SLEEP_REQ 4'h5
`define KIND_TRIG_EVT 4'h6
`define KIND_DATA 4'h7
`define KIND_REMOTE 4'h8

// Queue storage
`define QDEPTH 4'h8
`define QAW 3
`define QCW 4

// Remote frame modes
`define RMODE_OFF 2'h0
`define RMODE_PERIODIC 2'h1
`define RMODE_TRIGGER 2'h2
`define RMODE_ON_WRITE 2'h3

// Timing
`define CLK_KHZ 200000
`define INACT_TIME_MS 4000
`define INACT_CYCLES (`INACT_TIME_MS * `CLK_KHZ)
`define REMOTE_PERIOD_MS 10
`define REMOTE_CYCLES (`REMOTE_PERIOD_MS * `CLK_KHZ)

`endif

// *** verilog/lin_can_frame_queue_status.v ***
// Frame read and write queues with status flags for a LIN/CAN interface
`timescale 1ns/1ps
`include "lin_can_consts.vh"

module lin_can_frame_queue_status #(
  parameter [31:0] INACT_CYCLES = `INACT_CYCLES,
  parameter [31:0] REMOTE_CYCLES = `REMOTE_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Configuration; only the two queue depths are latched at communication start
  input wire comm_start,
  input wire [`QCW-1:0] rd_depth_cfg,
  input wire [`QCW-1:0] wr_depth_cfg,
  input wire [`QCW-1:0] notify_threshold_length,
  input wire log_bus_errors,
  input wire trig_log_en,
  input wire trig_out_en,
  input wire trig_tx_en,
  input wire auto_answer_en,
  input wire [1:0] remote_mode,
  input wire [11:0] obj_id,
  input wire [15:0] obj_data,
  input wire sleep_attr,
  input wire wakeup_cmd,
  // Host write side
  input wire wr_valid,
  input wire [`ITEM_W-1:0] wr_item,
  output reg write_overflow_error,
  // Host read side
  input wire rd_req,
  output wire [`ITEM_W-1:0] rd_item,
  output reg rd_valid,
  output reg stale_data_warning,
  output reg read_overflow,
  // State flags
  output wire read_available_state,
  output wire multi_read_threshold_state,
  output reg write_done_state,
  output wire sleeping,
  // Bus engine, receive side
  input wire rx_valid,
  input wire [3:0] rx_kind,
  input wire [11:0] rx_id,
  input wire [15:0] rx_data,
  input wire rx_error,
  input wire bus_activity,
  input wire break_sync,
  // Bus engine, transmit side
  output wire tx_valid,
  output wire [`ITEM_W-1:0] tx_item,
  input wire tx_ready,
  input wire tx_done,
  output reg wakeup_req,
  // Trigger lines
  input wire trigger_line,
  output reg trigger_line_out
);

  localparam [2:0] ST_AWAKE = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_DEAF = 3'b100;

  reg running_reg;
  reg [`QCW-1:0] rq_len_reg, wq_len_reg;
  reg [`QAW-1:0] rq_wp_reg, rq_rp_reg, wq_wp_reg, wq_rp_reg;
  reg [`QCW-1:0] rq_cnt_reg, wq_cnt_reg;
  reg [2:0] state_reg, state_next;
  reg [31:0] idle_cnt_reg;
  reg idle_fired_reg;
  reg [31:0] rem_cnt_reg;
  reg [15:0] stamp_reg;
  reg trig_d_reg;
  reg trig_pend_reg, inact_pend_reg, obj_pend_reg, rem_pend_reg;
  reg fetch_reg;
  reg [`ITEM_W-1:0] buf0_reg, buf1_reg;
  reg [1:0] buf_cnt_reg;
  reg sleep_d_reg;

  wire [`ITEM_W-1:0] wq_rdata;
  reg rq_we;
  reg [`ITEM_W-1:0] rq_wdata;
  reg [`ITEM_W-1:0] obj_item;
  reg rx_log;

  // Pointer advance, wrapping at the configured length
  function [`QAW-1:0] ptr_inc;
    input [`QAW-1:0] p;
    input [`QCW-1:0] len;
    begin
      if (len <= 4'h1) begin
        ptr_inc = {`QAW{1'b0}};
      end else if ({1'b0, p} == len - 4'h1) begin
        ptr_inc = {`QAW{1'b0}};
      end else begin
        ptr_inc = p + 3'h1;
      end
    end
  endfunction

  // Full only for a real queue; a zero-length one never refuses
  function q_full;
    input [`QCW-1:0] cnt;
    input [`QCW-1:0] len;
    begin
      q_full = (len != 4'h0) && (cnt >= len);
    end
  endfunction

  function [`ITEM_W-1:0] mk_item;
    input [3:0] kind;
    input [11:0] id;
    input [15:0] pay;
    begin
      mk_item = {kind, id, pay};
    end
  endfunction

  wire trig_rise = trigger_line & ~trig_d_reg;
  wire listening = running_reg && (state_reg == ST_AWAKE);
  wire rx_ok = rx_valid && listening;
  wire id_match = rx_ok && (rx_id == obj_id);
  wire rd_pop = rd_req && running_reg && (rq_cnt_reg != 4'h0);
  wire wq_push = wr_valid && running_reg && !q_full(wq_cnt_reg, wq_len_reg);
  wire wq_pop = running_reg && (state_reg == ST_AWAKE) && (wq_cnt_reg != 4'h0) &&
                (buf_cnt_reg == 2'h0) && !fetch_reg && !obj_pend_reg && !rem_pend_reg;
  wire obj_push = (obj_pend_reg || rem_pend_reg) && !fetch_reg && (buf_cnt_reg != 2'h2);
  wire buf_in = fetch_reg || obj_push;
  wire buf_out = tx_valid && tx_ready;

  assign read_available_state = rq_cnt_reg != 4'h0;
  assign multi_read_threshold_state = rq_cnt_reg > notify_threshold_length;
  assign sleeping = state_reg == ST_SLEEP;
  assign tx_valid = buf_cnt_reg != 2'h0;
  assign tx_item = buf0_reg;

  // Read queue source select; received frames win, others wait as pending
  always @* begin
    rq_we = 1'b0;
    rq_wdata = {`ITEM_W{1'b0}};
    rx_log = 1'b0;
    if (rx_ok) begin
      if (rx_error) begin
        rx_log = log_bus_errors;
        rq_wdata = mk_item(`KIND_BUS_ERR, rx_id, rx_data);
      end else if (rx_kind == `KIND_SLEEP_REQ) begin
        rx_log = 1'b1;
        rq_wdata = mk_item(`KIND_FULL, rx_id, rx_data);
      end else begin
        rx_log = 1'b1;
        rq_wdata = mk_item(rx_kind, rx_id, rx_data);
      end
      rq_we = rx_log;
    end else if (inact_pend_reg) begin
      rq_we = 1'b1;
      rq_wdata = mk_item(`KIND_INACTIVE, 12'h000, 16'h0000);
    end else if (trig_pend_reg) begin
      rq_we = 1'b1;
      rq_wdata = mk_item(`KIND_TRIG_EVT, 12'h000, stamp_reg);
    end
  end

  always @* begin
    if (rem_pend_reg) begin
      obj_item = mk_item(`KIND_REMOTE, obj_id, 16'h0000);
    end else begin
      obj_item = mk_item(`KIND_DATA, obj_id, obj_data);
    end
  end

  wire rq_full = q_full(rq_cnt_reg, rq_len_reg);
  wire rq_store = rq_we && running_reg && !rq_full;

  queue_mem rq_mem (
    .mclk(mclk),
    .rstn(rstn),
    .we(rq_store),
    .waddr(rq_wp_reg),
    .wdata(rq_wdata),
    .re(rd_pop),
    .raddr(rq_rp_reg),
    .rdata(rd_item)
  );

  queue_mem wq_mem (
    .mclk(mclk),
    .rstn(rstn),
    .we(wq_push),
    .waddr(wq_wp_reg),
    .wdata(wr_item),
    .re(wq_pop),
    .raddr(wq_rp_reg),
    .rdata(wq_rdata)
  );

  // Link state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_AWAKE: begin
        if (sleep_attr && !sleep_d_reg) begin
          state_next = ST_SLEEP;
        end else if (idle_fired_reg) begin
          state_next = ST_DEAF;
        end
      end
      ST_SLEEP: begin
        // own wakeup or bus wakes us
        if (wakeup_cmd || bus_activity) begin
          state_next = ST_AWAKE;
        end
      end
      ST_DEAF: begin
        if (break_sync) begin
          state_next = ST_AWAKE;
        end else if (sleep_attr && !sleep_d_reg) begin
          state_next = ST_SLEEP;
        end
      end
      default: state_next = ST_AWAKE;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      running_reg <= 1'b0;
      rq_len_reg <= 4'h0;
      wq_len_reg <= 4'h0;
      state_reg <= ST_AWAKE;
      sleep_d_reg <= 1'b0;
      trig_d_reg <= 1'b0;
      stamp_reg <= 16'h0000;
      wakeup_req <= 1'b0;
      trigger_line_out <= 1'b0;
    end else begin
      stamp_reg <= stamp_reg + 16'h0001;
      trig_d_reg <= trigger_line;
      sleep_d_reg <= sleep_attr;
      wakeup_req <= (state_reg == ST_SLEEP) && wakeup_cmd;
      trigger_line_out <= trig_out_en && id_match && !rx_error;
      if (comm_start) begin
        running_reg <= 1'b1;
        // independent depths, fixed from here on
        rq_len_reg <= (rd_depth_cfg > `QDEPTH) ? `QDEPTH : rd_depth_cfg;
        wq_len_reg <= (wr_depth_cfg > `QDEPTH) ? `QDEPTH : wr_depth_cfg;
        state_reg <= ST_AWAKE;
      end else begin
        state_reg <= state_next;
      end
    end
  end

  // Inactivity timer, fires once per silence
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_reg <= 32'h0000_0000;
      idle_fired_reg <= 1'b0;
      inact_pend_reg <= 1'b0;
    end else begin
      idle_fired_reg <= 1'b0;
      if (!running_reg || bus_activity || rx_valid || break_sync || comm_start) begin
        idle_cnt_reg <= 32'h0000_0000;
      end else if (idle_cnt_reg < INACT_CYCLES) begin
        idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
        // bus inactive entry, master or slave alike
        if (idle_cnt_reg == INACT_CYCLES - 32'h0000_0001) begin
          idle_fired_reg <= 1'b1;
        end
      end
      if (idle_fired_reg) begin
        inact_pend_reg <= 1'b1;
      end else if (!rx_ok) begin
        inact_pend_reg <= 1'b0;
      end
    end
  end

  // Object requests: trigger log, triggered send, remote, auto answer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trig_pend_reg <= 1'b0;
      obj_pend_reg <= 1'b0;
      rem_pend_reg <= 1'b0;
      rem_cnt_reg <= 32'h0000_0000;
    end else begin
      // timestamped trigger entry, kept until it gets its turn at the read queue, then dropped if the queue is full
      if (running_reg && trig_log_en && trig_rise) begin
        trig_pend_reg <= 1'b1;
      end else if (!rx_ok && !inact_pend_reg) begin
        trig_pend_reg <= 1'b0;
      end
      // triggered send; answer a matching remote frame
      if (running_reg && ((trig_tx_en && trig_rise) ||
          (auto_answer_en && id_match && !rx_error && rx_kind == `KIND_REMOTE))) begin
        obj_pend_reg <= 1'b1;
      end else if (obj_push && !rem_pend_reg) begin
        obj_pend_reg <= 1'b0;
      end
      if (remote_mode == `RMODE_PERIODIC && running_reg) begin
        if (rem_cnt_reg >= REMOTE_CYCLES - 32'h0000_0001) begin
          rem_cnt_reg <= 32'h0000_0000;
        end else begin
          rem_cnt_reg <= rem_cnt_reg + 32'h0000_0001;
        end
      end else begin
        rem_cnt_reg <= 32'h0000_0000;
      end
      if (running_reg &&
          ((remote_mode == `RMODE_PERIODIC && rem_cnt_reg >= REMOTE_CYCLES - 32'h0000_0001) ||
           (remote_mode == `RMODE_TRIGGER && trig_rise) ||
           (remote_mode == `RMODE_ON_WRITE && wr_valid))) begin
        rem_pend_reg <= 1'b1;
      end else if (obj_push) begin
        rem_pend_reg <= 1'b0;
      end
    end
  end

  // Read queue pointers and read answer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rq_wp_reg <= 3'h0;
      rq_rp_reg <= 3'h0;
      rq_cnt_reg <= 4'h0;
      rd_valid <= 1'b0;
      stale_data_warning <= 1'b0;
      read_overflow <= 1'b0;
    end else if (comm_start) begin
      rq_wp_reg <= 3'h0;
      rq_rp_reg <= 3'h0;
      rq_cnt_reg <= 4'h0;
      rd_valid <= 1'b0;
      stale_data_warning <= 1'b0;
      read_overflow <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      // empty read repeats last item, flagged stale
      stale_data_warning <= rd_req && !rd_pop;
      // arrival into a full read queue is dropped
      read_overflow <= rq_we && running_reg && rq_full;
      if (rq_len_reg == 4'h0) begin
        // single slot overwrite, read_overflow never set
        if (rq_store) begin
          rq_cnt_reg <= 4'h1;
        end else if (rd_pop) begin
          rq_cnt_reg <= 4'h0;
        end
      end else begin
        // arrival order; a load raises the count unless a read pops in the same cycle
        if (rq_store) begin
          rq_wp_reg <= ptr_inc(rq_wp_reg, rq_len_reg);
        end
        if (rd_pop) begin
          rq_rp_reg <= ptr_inc(rq_rp_reg, rq_len_reg);
        end
        if (rq_store && !rd_pop) begin
          rq_cnt_reg <= rq_cnt_reg + 4'h1;
        end else if (rd_pop && !rq_store) begin
          rq_cnt_reg <= rq_cnt_reg - 4'h1;
        end
      end
    end
  end

  // Write queue, fetch stage and write done
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wq_wp_reg <= 3'h0;
      wq_rp_reg <= 3'h0;
      wq_cnt_reg <= 4'h0;
      fetch_reg <= 1'b0;
      write_overflow_error <= 1'b0;
      write_done_state <= 1'b1;
    end else if (comm_start) begin
      wq_wp_reg <= 3'h0;
      wq_rp_reg <= 3'h0;
      wq_cnt_reg <= 4'h0;
      fetch_reg <= 1'b0;
      write_overflow_error <= 1'b0;
      write_done_state <= 1'b1;
    end else begin
      fetch_reg <= wq_pop;
      write_overflow_error <= wr_valid && running_reg && q_full(wq_cnt_reg, wq_len_reg);
      if (wq_len_reg == 4'h0) begin
        // newest item replaces the held one
        if (wq_push) begin
          wq_cnt_reg <= 4'h1;
        end else if (wq_pop) begin
          wq_cnt_reg <= 4'h0;
        end
      end else begin
        // one at a time, first in first out
        if (wq_push) begin
          wq_wp_reg <= ptr_inc(wq_wp_reg, wq_len_reg);
        end
        if (wq_pop) begin
          wq_rp_reg <= ptr_inc(wq_rp_reg, wq_len_reg);
        end
        if (wq_push && !wq_pop) begin
          wq_cnt_reg <= wq_cnt_reg + 4'h1;
        end else if (wq_pop && !wq_push) begin
          wq_cnt_reg <= wq_cnt_reg - 4'h1;
        end
      end
      // set on last successful send, cleared by a new write
      if (wq_push) begin
        write_done_state <= 1'b0;
      end else if (tx_done && wq_cnt_reg == 4'h0 && !fetch_reg &&
                   buf_cnt_reg == 2'h0) begin
        write_done_state <= 1'b1;
      end
    end
  end

  // Two-entry transmit buffer; a stalled engine holds items, none lost
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buf0_reg <= {`ITEM_W{1'b0}};
      buf1_reg <= {`ITEM_W{1'b0}};
      buf_cnt_reg <= 2'h0;
    end else if (comm_start) begin
      buf_cnt_reg <= 2'h0;
    end else begin
      // host header items go out to the engine as queued
      case ({buf_in, buf_out})
        2'b10: begin
          if (buf_cnt_reg == 2'h0) begin
            buf0_reg <= fetch_reg ? wq_rdata : obj_item;
          end else begin
            buf1_reg <= fetch_reg ? wq_rdata : obj_item;
          end
          buf_cnt_reg <= buf_cnt_reg + 2'h1;
        end
        2'b01: begin
          buf0_reg <= buf1_reg;
          buf_cnt_reg <= buf_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_reg == 2'h1) begin
            buf0_reg <= fetch_reg ? wq_rdata : obj_item;
          end else begin
            buf0_reg <= buf1_reg;
            buf1_reg <= fetch_reg ? wq_rdata : obj_item;
          end
        end
        default: begin
          buf_cnt_reg <= buf_cnt_reg;
        end
      endcase
    end
  end

endmodule

// *** verilog/queue_mem.v ***
// Small queue storage with registered read data
`timescale 1ns/1ps
`include "lin_can_consts.vh"

module queue_mem (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Write port
  input wire we,
  input wire [`QAW-1:0] waddr,
  input wire [`ITEM_W-1:0] wdata,
  // Read port
  input wire re,
  input wire [`QAW-1:0] raddr,
  output reg [`ITEM_W-1:0] rdata
);

  reg [`ITEM_W-1:0] mem [0:`QDEPTH-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data only moves on a read, so an empty read repeats the last item
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= {`ITEM_W{1'b0}};
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
